//--- hw/cpu_reset_init.sv
/*
 Reset acceptance and CPU/peripheral initialisation sequencer with an
 AHB-Lite register slave. Assumes the reset pin is asynchronous and that
 the board holds it low long enough.
*/
// Function
// - Reset forces clock gear to 1/16
// - PC loaded from three vector bytes
// - System stack pointer set to 100h
// - Interrupt mask level set to seven
// - Maximum mode flag set
// - Register bank pointer cleared
// - Fetch starts at vector after release
// - Other CPU registers and RAM untouched
// - Peripherals reset, pins become ports
// - Watchdog pin low, watchdog enabled
// - Clock pin released, pulled high
// - Address latch pin goes high-Z
`default_nettype none
module cpu_reset_init #(
   parameter int unsigned MIN_LOW = rst_init_pkg::MIN_LOW_CLOCKS,
   parameter logic [23:0] VECTOR = 24'h00A000
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Reset pin from the board
   input wire logic reset_pin_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [7:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // CPU state
   output logic [23:0] pc_o,
   output logic [23:0] system_stack_pointer_o,
   output rst_init_pkg::status_s status_o,
   output logic cpu_run_o,
   output logic [2:0] gear_o,
   output logic periph_rst_o,
   output logic port_mode_o,
   // Pins
   output logic watchdog_output_pin_o,
   output logic watchdog_en_o,
   output logic clk_pin_o,
   output logic clk_pin_oe_o,
   output logic ale_pin_o,
   output logic ale_pin_oe_o
);
   logic rst_s1_q, rst_s2_q;
   logic pin_s1_q, pin_s2_q;
   logic [7:0] low_cnt_q;
   logic in_reset_q;
   rst_init_pkg::seq_state_e state_q;
   logic [1:0] rom_addr_q;
   logic [7:0] rom_data;
   logic [31:0] ctrl_q;
   logic clk_div_q;
   rst_init_pkg::ahb_addr_s ap_q;
   logic wr_ctrl;
   logic start_load;

   // Vector byte indices inside the small vector memory
   localparam int unsigned ROM_DEPTH = 4;
   localparam logic [1:0] BYTE_LO = rst_init_pkg::VEC_ADDR_LO[1:0];
   localparam logic [1:0] BYTE_MID = rst_init_pkg::VEC_ADDR_MID[1:0];
   localparam logic [1:0] BYTE_HI = rst_init_pkg::VEC_ADDR_HI[1:0];

   // A new load may start unless one is already under way
   function automatic logic load_idle(input rst_init_pkg::seq_state_e s);
      case (s)
         rst_init_pkg::ST_FETCH_LO, rst_init_pkg::ST_FETCH_MID: load_idle = 1'b0;
         rst_init_pkg::ST_FETCH_HI, rst_init_pkg::ST_WAIT_REL: load_idle = 1'b0;
         default: load_idle = 1'b1;
      endcase
   endfunction

   // Accepted reset arms a fresh vector load
   assign start_load = in_reset_q && load_idle(state_q);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   // Internal reset asserts at once and releases two clocks later
   wire rst_n = rst_s2_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
      end else begin
         pin_s1_q <= reset_pin_n_i;
         pin_s2_q <= pin_s1_q;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt_q <= 8'h00;
         in_reset_q <= 1'b1;
      end else if (pin_s2_q) begin
         low_cnt_q <= 8'h00;
         in_reset_q <= 1'b0;
      end else if (low_cnt_q < MIN_LOW[7:0]) begin
         low_cnt_q <= low_cnt_q + 8'h01;
         if (low_cnt_q + 8'h01 >= MIN_LOW[7:0]) begin
            in_reset_q <= 1'b1;
         end
      end
   end

   // Reset sequencer
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= rst_init_pkg::ST_HOLD;
         rom_addr_q <= BYTE_LO;
         pc_o <= 24'h000000;
         system_stack_pointer_o <= 24'h000000;
         status_o <= '0;
         cpu_run_o <= 1'b0;
      end else if (start_load) begin
         state_q <= rst_init_pkg::ST_FETCH_LO;
         rom_addr_q <= BYTE_MID;
         cpu_run_o <= 1'b0;
         system_stack_pointer_o <= rst_init_pkg::SYS_SP_RESET;
         status_o.imask <= rst_init_pkg::IMASK_RESET;
         status_o.max_mode <= rst_init_pkg::MAX_MODE_RESET;
         status_o.bank <= rst_init_pkg::BANK_RESET;
         // other CPU state has no path here
      end else begin
         case (state_q)
            rst_init_pkg::ST_FETCH_LO: begin
               pc_o[7:0] <= rom_data;
               rom_addr_q <= BYTE_HI;
               state_q <= rst_init_pkg::ST_FETCH_MID;
            end
            rst_init_pkg::ST_FETCH_MID: begin
               pc_o[15:8] <= rom_data;
               state_q <= rst_init_pkg::ST_FETCH_HI;
            end
            rst_init_pkg::ST_FETCH_HI: begin
               pc_o[23:16] <= rom_data;
               state_q <= rst_init_pkg::ST_WAIT_REL;
            end
            rst_init_pkg::ST_WAIT_REL: begin
               // Vector loaded; waits for the pin to rise
               // start fetch on release
               if (!in_reset_q) begin
                  cpu_run_o <= 1'b1;
                  state_q <= rst_init_pkg::ST_RUN;
               end
            end
            rst_init_pkg::ST_HOLD: begin
               // No reset accepted yet: CPU held
               cpu_run_o <= 1'b0;
            end
            rst_init_pkg::ST_RUN: begin
               // Run flag stays set whatever software writes to CTRL_RUN
               cpu_run_o <= ctrl_q[rst_init_pkg::CTRL_RUN] | cpu_run_o;
            end
            default: state_q <= rst_init_pkg::ST_HOLD;
         endcase
      end
   end

   // Low byte address is shown while a load is armed
   vector_rom #(
      .DEPTH(ROM_DEPTH),
      .VECTOR(VECTOR)
   ) u_rom (
      .ref_clk_i(ref_clk_i),
      .addr_i(start_load ? BYTE_LO : rom_addr_q),
      .rdata_o(rom_data)
   );

   // AHB address phase capture
   // Only NONSEQ transfers to this slave count as selected
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ap_q <= '0;
      end else if (hready_i) begin
         ap_q.hsel <= hsel_i && htrans_i == rst_init_pkg::HTRANS_NONSEQ;
         ap_q.htrans <= htrans_i;
         ap_q.haddr <= haddr_i;
         ap_q.hwrite <= hwrite_i;
         ap_q.hsize <= hsize_i;
      end
   end
   // Write data are taken at the end of the data phase
   assign wr_ctrl = ap_q.hsel && ap_q.hwrite && ap_q.haddr == rst_init_pkg::REG_CTRL;

   // Control register; reset forces peripheral defaults
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= rst_init_pkg::CTRL_RESET;
      end else if (in_reset_q) begin
         ctrl_q <= rst_init_pkg::CTRL_RESET | (32'h1 << rst_init_pkg::CTRL_WDT_EN);
      end else if (wr_ctrl) begin
         ctrl_q <= hwdata_i;
      end
   end

   // Read data and slave response
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_o <= 32'h00000000;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
         hrdata_o <= 32'h00000000;
         // Decoded in the address phase, shown in the data phase
         if (hready_i && hsel_i && htrans_i == rst_init_pkg::HTRANS_NONSEQ && !hwrite_i) begin
            case (haddr_i)
               rst_init_pkg::REG_CTRL: hrdata_o <= ctrl_q;
               rst_init_pkg::REG_STAT: hrdata_o <= {24'h0, status_o, in_reset_q};
               rst_init_pkg::REG_PC: hrdata_o <= {8'h00, pc_o};
               rst_init_pkg::REG_SP: hrdata_o <= {8'h00, system_stack_pointer_o};
               rst_init_pkg::REG_PORT: hrdata_o <= {29'h0, port_mode_o, cpu_run_o,
                                                     periph_rst_o};
               default: hrdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   // Clock output divider
   // Toggles every clock: half the system rate on the pin
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         clk_div_q <= 1'b0;
      end else begin
         clk_div_q <= ~clk_div_q;
      end
   end

   // Pin and peripheral reset states
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gear_o <= rst_init_pkg::GEAR_DIV16;
         periph_rst_o <= 1'b1;
         port_mode_o <= 1'b0;
         watchdog_output_pin_o <= 1'b0;
         watchdog_en_o <= 1'b1;
         clk_pin_o <= 1'b1;
         clk_pin_oe_o <= 1'b0;
         ale_pin_o <= 1'b0;
         ale_pin_oe_o <= 1'b0;
      end else if (in_reset_q) begin
         gear_o <= rst_init_pkg::GEAR_DIV16;
         periph_rst_o <= 1'b1;
         port_mode_o <= 1'b0;
         watchdog_output_pin_o <= 1'b0;
         watchdog_en_o <= 1'b1;
         clk_pin_o <= 1'b1;
         clk_pin_oe_o <= 1'b0;
         ale_pin_o <= 1'b0;
         ale_pin_oe_o <= 1'b0;
      end else begin
         gear_o <= ctrl_q[rst_init_pkg::CTRL_GEAR_LSB +: 3];
         periph_rst_o <= 1'b0;
         port_mode_o <= 1'b1;
         watchdog_output_pin_o <= ctrl_q[rst_init_pkg::CTRL_WDT_OUT];
         watchdog_en_o <= ctrl_q[rst_init_pkg::CTRL_WDT_EN];
         clk_pin_o <= clk_div_q;
         clk_pin_oe_o <= ctrl_q[rst_init_pkg::CTRL_CLK_EN];
         ale_pin_o <= 1'b0;
         ale_pin_oe_o <= ctrl_q[rst_init_pkg::CTRL_ALE_EN];
      end
   end
endmodule // cpu_reset_init
`default_nettype wire

//--- hw/vector_rom.sv
/*
 Small memory holding the three reset vector bytes.
 Assumes a byte address from the sequencer; read data are registered.
*/
`default_nettype none
module vector_rom #(
   parameter int unsigned DEPTH = 4,
   parameter logic [23:0] VECTOR = 24'h00A000
) (
   input wire logic ref_clk_i,
   input wire logic [1:0] addr_i,
   output logic [7:0] rdata_o
);
   logic [7:0] mem_q [DEPTH];

   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         mem_q[i] = 8'h00;
      end
      mem_q[0] = VECTOR[7:0];
      mem_q[1] = VECTOR[15:8];
      mem_q[2] = VECTOR[23:16];
   end

   always_ff @(posedge ref_clk_i) begin
      rdata_o <= mem_q[addr_i];
   end
endmodule // vector_rom
`default_nettype wire

//--- include/rst_init_pkg.sv
/*
 Package for the reset acceptance and initialisation block: register map,
 reset values, field layouts and timing constants.
 Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package rst_init_pkg;
   // Reset filter and pin timing
   localparam int unsigned MIN_LOW_CLOCKS = 10;
   localparam int unsigned SYNC_STAGES = 2;
   // Clock gear
   localparam logic [2:0] GEAR_DIV16 = 3'h4;
   localparam logic [2:0] GEAR_DIV1 = 3'h0;
   // Reset vector addresses
   localparam logic [23:0] VEC_ADDR_LO = 24'h008000;
   localparam logic [23:0] VEC_ADDR_MID = 24'h008001;
   localparam logic [23:0] VEC_ADDR_HI = 24'h008002;
   // CPU reset values
   localparam logic [23:0] SYS_SP_RESET = 24'h000100;
   localparam logic [2:0] IMASK_RESET = 3'h7;
   localparam logic MAX_MODE_RESET = 1'b1;
   localparam logic [2:0] BANK_RESET = 3'h0;
   // Reserved top region
   localparam logic [23:0] RESV_BASE = 24'hFFFF00;
   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_PC = 8'h08;
   localparam logic [7:0] REG_SP = 8'h0C;
   localparam logic [7:0] REG_PORT = 8'h10;
   // CTRL fields
   localparam int unsigned CTRL_GEAR_LSB = 0;
   localparam int unsigned CTRL_WDT_EN = 4;
   localparam int unsigned CTRL_WDT_OUT = 5;
   localparam int unsigned CTRL_CLK_EN = 6;
   localparam int unsigned CTRL_ALE_EN = 7;
   localparam int unsigned CTRL_RUN = 8;
   localparam logic [31:0] CTRL_RESET = 32'h00000004;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [2:0] {
      ST_HOLD,
      ST_FETCH_LO,
      ST_FETCH_MID,
      ST_FETCH_HI,
      ST_WAIT_REL,
      ST_RUN
   } seq_state_e;

   typedef struct packed {
      logic [2:0] imask;
      logic max_mode;
      logic [2:0] bank;
   } status_s;

   typedef struct packed {
      logic [1:0] htrans;
      logic [7:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
   } ahb_addr_s;
endpackage
`default_nettype wire

//--- testbench/cpu_reset_init_properties.sv
/*
 Checker for the reset filter, reset values and pin states.
 Assumes it is bound to cpu_reset_init and sees only its ports.
*/
`default_nettype none
module cpu_reset_init_checker #(
   parameter int unsigned MIN_LOW = 10,
   parameter logic [23:0] VECTOR = 24'h00A000
) (
   // Clock, reset and pin
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic reset_pin_n_i,
   // CPU state
   input wire logic [23:0] pc_o,
   input wire logic [23:0] system_stack_pointer_o,
   input wire rst_init_pkg::status_s status_o,
   input wire logic cpu_run_o,
   input wire logic [2:0] gear_o,
   input wire logic periph_rst_o,
   input wire logic port_mode_o,
   // Pins
   input wire logic watchdog_output_pin_o,
   input wire logic watchdog_en_o,
   input wire logic clk_pin_oe_o,
   input wire logic ale_pin_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] low_cnt_q;
   logic long_q;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Current low run of the pin and whether it reached the minimum
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         low_cnt_q <= 5'h00;
         long_q <= 1'b0;
      end else if (reset_pin_n_i) begin
         low_cnt_q <= 5'h00;
         long_q <= 1'b0;
      end else begin
         low_cnt_q <= (low_cnt_q == 5'h1F) ? low_cnt_q : low_cnt_q + 5'h01;
         long_q <= (32'(low_cnt_q) + 32'd1) >= MIN_LOW;
      end
   end
   sequence s_release;
      $rose(reset_pin_n_i) && long_q;
   endsequence
   sequence s_start;
      $rose(cpu_run_o);
   endsequence
   a_short_ignored: assert property ($fell(cpu_run_o) |-> long_q)
      else $error("run stopped by a short pin pulse");
   a_gear_slow: assert property ($rose(long_q) |-> ##[1:6] gear_o == 3'h4)
      else $error("gear not forced to slowest");
   a_run_release: assert property (s_release |-> ##[1:6] cpu_run_o)
      else $error("no fetch after release");
   a_pc_vector: assert property (s_start |-> pc_o == VECTOR)
      else $error("pc not from vector");
   a_status_init: assert property (s_start |->
      status_o == 7'h78 && system_stack_pointer_o == 24'h000100)
      else $error("status or stack pointer wrong");
   a_wdt_reset: assert property (periph_rst_o |->
      !watchdog_output_pin_o && watchdog_en_o)
      else $error("watchdog pin state wrong in reset");
   a_pins_released: assert property (periph_rst_o |->
      !clk_pin_oe_o && !ale_pin_oe_o)
      else $error("clock or latch pin driven in reset");
   a_port_general: assert property (periph_rst_o |-> !port_mode_o)
      else $error("pins not general ports in reset");
endmodule // cpu_reset_init_checker
bind cpu_reset_init cpu_reset_init_checker #(.MIN_LOW(MIN_LOW), .VECTOR(VECTOR)) u_chk (
   .ref_clk_i(ref_clk_i),
   .arst_n_i(arst_n_i),
   .reset_pin_n_i(reset_pin_n_i),
   .pc_o(pc_o),
   .system_stack_pointer_o(system_stack_pointer_o),
   .status_o(status_o),
   .cpu_run_o(cpu_run_o),
   .gear_o(gear_o),
   .periph_rst_o(periph_rst_o),
   .port_mode_o(port_mode_o),
   .watchdog_output_pin_o(watchdog_output_pin_o),
   .watchdog_en_o(watchdog_en_o),
   .clk_pin_oe_o(clk_pin_oe_o),
   .ale_pin_oe_o(ale_pin_oe_o)
);
`default_nettype wire

//--- testbench/reset_source.sv
/*
 Board supervisor model driving the reset pin.
 Assumes a pull-up on the pin, so a released pin reads high.
*/
`default_nettype none
module reset_source (
   // Clock
   input wire logic ref_clk_i,
   // Reset pin
   output var logic reset_pin_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial reset_pin_n_o = 1'b1;
   task automatic pulse(input int n);
      @(posedge ref_clk_i);
      reset_pin_n_o <= 1'b0;
      repeat (n) @(posedge ref_clk_i);
      reset_pin_n_o <= 1'b1;
   endtask
endmodule // reset_source
`default_nettype wire

//--- testbench/test_cpu_reset_init.sv
/*
 Testbench: reset pulses and register accesses over AHB-Lite.
 Assumes the checker is bound and the reset source model drives the pin.
*/
`default_nettype none
module test_cpu_reset_init;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [23:0] VEC = 24'h3CC35A;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic pin_n, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hready, cpu_run, prst, pmode, wdt_pin, wdt_en, clk_oe, ale_oe;
   logic hresp, clk_pin, ale_pin;
   logic [23:0] pc, sp;
   logic [2:0] gear;
   rst_init_pkg::status_s status;
   int mismatches = 0;
   int comparisons = 0;
   always #4 ref_clk_i = ~ref_clk_i;
   reset_source u_src (.ref_clk_i(ref_clk_i), .reset_pin_n_o(pin_n));
   cpu_reset_init #(.MIN_LOW(10), .VECTOR(VEC)) dut (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .reset_pin_n_i(pin_n),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
      .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
      .hreadyout_o(hready), .hresp_o(hresp), .pc_o(pc), .system_stack_pointer_o(sp),
      .status_o(status), .cpu_run_o(cpu_run), .gear_o(gear), .periph_rst_o(prst),
      .port_mode_o(pmode), .watchdog_output_pin_o(wdt_pin), .watchdog_en_o(wdt_en),
      .clk_pin_o(clk_pin), .clk_pin_oe_o(clk_oe), .ale_pin_o(ale_pin), .ale_pin_oe_o(ale_oe)
   );
   task automatic finish_test();
      $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= rst_init_pkg::HTRANS_NONSEQ;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      r = hrdata;
   endtask
   // Long pin pulse, checks while held and after release
   task automatic full_reset();
      fork
         u_src.pulse(24);
         begin
            repeat (22) @(posedge ref_clk_i);
            chk(32'(gear), 32'h4);
            chk(32'({wdt_pin, wdt_en, clk_oe, ale_oe}), 32'h4);
            chk(32'({prst, pmode}), 32'h2);
            chk(32'({clk_pin, ale_pin, hresp}), 32'h4);
         end
      join
      for (int i = 0; i < 10 && cpu_run !== 1'b1; i++) @(posedge ref_clk_i);
      chk(32'(cpu_run), 32'h1);
      chk(32'(pc), 32'(VEC));
      chk(32'(sp), 32'h100);
      chk(32'(status), 32'h78);
   endtask
   initial begin
      repeat (20) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      full_reset();
      bus(1'b1, 8'h00, 32'hE0, rd);
      bus(1'b0, 8'h00, 32'h0, rd);
      chk(rd, 32'hE0);
      chk(32'({gear, wdt_pin, clk_oe, ale_oe}), 32'h07);
      bus(1'b1, 8'h08, 32'h0, rd);
      bus(1'b0, 8'h08, 32'h0, rd);
      chk(rd, 32'(VEC));
      bus(1'b0, 8'h0C, 32'h0, rd);
      chk(rd, 32'h100);
      bus(1'b0, 8'h04, 32'h0, rd);
      chk(rd, 32'hF0);
      bus(1'b0, 8'h10, 32'h0, rd);
      chk(rd, 32'h6);
      bus(1'b0, 8'h20, 32'h0, rd);
      chk(rd, 32'h0);
      // Pulse one clock short of the minimum
      u_src.pulse(9);
      repeat (20) @(posedge ref_clk_i);
      chk(32'({gear, cpu_run}), 32'h1);
      full_reset();
      finish_test();
   end
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      mismatches++;
      finish_test();
   end
endmodule // test_cpu_reset_init
`default_nettype wire
